//--- hw/xps_chain.sv
// Serial programming chain of a 16 by 16 crosspoint switch.
// Assumes the serial clock, data, select and update pins come from a host
// on an unrelated clock; each is synchronised before any logic reads it.
`default_nettype none
module xps_chain
    import xps_pkg::*;
#(
    parameter int WORD_BITS = XPS_WORD_BITS
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Serial programming pins
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_select_n,
    input wire logic i_update_n,
    // Chain output
    output logic o_serial_data,
    // Matrix control
    output logic [WORD_BITS-1:0] o_matrix,
    output logic o_outputs_enable_n
);
    // ------------------------------------------------------------
    // Local types
    // ------------------------------------------------------------
    typedef enum logic {
        OUT_DISABLED,
        OUT_LIVE
    } xps_out_state_type;

    // ------------------------------------------------------------
    // Local storage
    // ------------------------------------------------------------
    logic sclk;
    logic sdata;
    logic sel_n;
    logic upd_n;
    logic sclk_prev;
    logic upd_prev_n;
    logic shift_take;
    logic load_take;
    logic [WORD_BITS-1:0] shift;
    logic [WORD_BITS-1:0] next_shift;
    logic [WORD_BITS-1:0] next_matrix;
    logic next_serial_data;
    xps_out_state_type out_state;
    xps_out_state_type next_out_state;

    // ------------------------------------------------------------
    // Edge decoding
    // ------------------------------------------------------------
    // Edges are judged on synchronised levels against their own history, never
    // on the raw pin, so a pin moving near i_clock cannot fake a second edge.
    function automatic logic level_moved(input logic now_level, input logic prev_level,
        input logic to_level);
        return (now_level == to_level) && (prev_level != to_level);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Clock and data share the same synchroniser delay, so each bit is read
    // together with the serial clock edge that belongs to it.
    xps_sync u_sync_clk (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pin(i_serial_clock),
        .o_level(sclk)
    );

    xps_sync u_sync_data (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pin(i_serial_data),
        .o_level(sdata)
    );

    xps_sync u_sync_sel (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pin(i_select_n),
        .o_level(sel_n)
    );

    xps_sync u_sync_upd (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pin(i_update_n),
        .o_level(upd_n)
    );

    // ------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_prev <= XPS_SYNC_RESET;
        end else begin
            sclk_prev <= sclk;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            upd_prev_n <= XPS_SYNC_RESET;
        end else begin
            upd_prev_n <= upd_n;
        end
    end

    always_comb begin
        shift_take = level_moved(sclk, sclk_prev, 1'h1) && !sel_n;
    end

    always_comb begin
        load_take = level_moved(upd_n, upd_prev_n, 1'h0);
    end

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    // Data is sampled on the synchronised rising serial clock edge, so the host
    // serial clock must stay below a quarter of i_clock.
    always_comb begin
        next_shift = shift;
        if (shift_take) begin
            next_shift = {shift[WORD_BITS-2:0], sdata};
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift <= '0;
        end else begin
            shift <= next_shift;
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    always_comb begin
        next_serial_data = shift[WORD_BITS-1];
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_data <= XPS_DATA_RESET;
        end else begin
            o_serial_data <= next_serial_data;
        end
    end

    // ------------------------------------------------------------
    // Matrix latches
    // ------------------------------------------------------------
    // The update strobe is shared by a whole chain, so it loads regardless of
    // the select; a falling edge loads once even if held low for long.
    always_comb begin
        next_matrix = o_matrix;
        if (load_take) begin
            next_matrix = shift;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_matrix <= '0;
        end else begin
            o_matrix <= next_matrix;
        end
    end

    // ------------------------------------------------------------
    // Output enable state
    // ------------------------------------------------------------
    // Outputs stay off from reset until a whole pattern has been applied, so
    // wired outputs of several devices never fight after power-up.
    always_comb begin
        next_out_state = out_state;
        case (out_state)
            OUT_DISABLED: begin
                if (load_take) begin
                    next_out_state = OUT_LIVE;
                end
            end
            OUT_LIVE: begin
                next_out_state = OUT_LIVE;
            end
            default: begin
                next_out_state = OUT_DISABLED;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_state <= OUT_DISABLED;
        end else begin
            out_state <= next_out_state;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_outputs_enable_n <= XPS_OE_N_RESET;
        end else begin
            o_outputs_enable_n <= (next_out_state != OUT_LIVE);
        end
    end
endmodule
`default_nettype wire

//--- hw/xps_pkg.sv
// Package for the crosspoint serial programming block.
// Assumes a single 10 MHz system clock and that all serial pins are asynchronous.
`default_nettype none
package xps_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int XPS_WORD_BITS = 80;
    localparam int XPS_SYNC_STAGES = 2;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic XPS_SYNC_RESET = 1'h1;
    localparam logic XPS_DATA_RESET = 1'h0;
    localparam logic XPS_OE_N_RESET = 1'h1;
endpackage
`default_nettype wire

//--- hw/xps_sync.sv
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin is unrelated to i_clock; first flop feeds only the second.
`default_nettype none
module xps_sync
    import xps_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Pin and result
    input wire logic i_pin,
    output logic o_level
);
    logic meta;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= XPS_SYNC_RESET;
            o_level <= XPS_SYNC_RESET;
        end else begin
            meta <= i_pin;
            o_level <= meta;
        end
    end
endmodule
`default_nettype wire

//--- tb/xps_chain_asserts.sv
// Checker for the serial chain ports of one crosspoint device.
// Assumes one clock domain and host pins synchronised inside the device.
`default_nettype none
module xps_chain_asserts #(parameter int WORD_BITS = 80) (input wire logic i_clock, i_rst_n,
    i_serial_clock, i_serial_data, i_select_n, i_update_n, o_serial_data,
    input wire logic [WORD_BITS-1:0] o_matrix, input wire logic o_outputs_enable_n);
    timeunit 1ns; timeprecision 1ns;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    rst_off_a: assert property (disable iff (1'b0)
        !i_rst_n |=> o_outputs_enable_n && o_matrix == '0 && !o_serial_data)
        else $error("live in reset");
    update_load_a: assert property ($fell(i_update_n) |-> ##3 !o_outputs_enable_n)
        else $error("no load");
    enable_stay_a: assert property (!o_outputs_enable_n |=> !o_outputs_enable_n)
        else $error("enable dropped");
    matrix_hold_a: assert property ($changed(o_matrix) |->
        $past(i_update_n, 4) && !$past(i_update_n, 3)) else $error("matrix moved");
    shift_out_a: assert property ($changed(o_serial_data) |->
        !$past(i_serial_clock, 5) && $past(i_serial_clock, 4)) else $error("stray shift");
    select_gate_a: assert property ($changed(o_serial_data) |-> !$past(i_select_n, 4))
        else $error("shift unselected");
endmodule
bind xps_chain xps_chain_asserts #(.WORD_BITS(WORD_BITS)) chk_u (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_serial_clock(i_serial_clock), .i_serial_data(i_serial_data),
    .i_select_n(i_select_n), .i_update_n(i_update_n), .o_serial_data(o_serial_data),
    .o_matrix(o_matrix), .o_outputs_enable_n(o_outputs_enable_n));
`default_nettype wire

//--- tb/xps_host.sv
// Host model driving the serial programming pins of a device.
// Assumes a free-running i_clock; the serial clock idles low between frames.
`default_nettype none
module xps_host (input wire logic i_clock, output logic o_sck, output logic o_sdata,
    output logic o_sel_n, output logic o_upd_n);
    timeunit 1ns; timeprecision 1ns;
    initial begin
        {o_sck, o_sdata, o_sel_n, o_upd_n} = 4'h3;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic sel(input logic v);
        o_sel_n = v;
        wait_n(3);
    endtask
    // Three cycles per half keeps data steady across the synchronised edge.
    task automatic shift_word(input logic [79:0] w);
        for (int i = 79; i >= 0; i--) begin
            o_sdata = w[i];
            wait_n(3);
            o_sck = 1'b1;
            wait_n(3);
            o_sck = 1'b0;
        end
        o_sdata = ~o_sdata;
        wait_n(1);
    endtask
    task automatic strobe();
        wait_n(3);
        o_upd_n = 1'b0;
        wait_n(3);
        o_upd_n = 1'b1;
        wait_n(3);
    endtask
endmodule
`default_nettype wire

//--- tb/xps_chain_tb_top.sv
// Testbench for the crosspoint serial chain.
// Assumes the host model and checker files are compiled first.
`default_nettype none
module xps_chain_tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic i_clock = 0, i_rst_n = 0, sout, oe_n, sout2, oe2_n;
    logic [79:0] mat, mat2;
    wire logic sck, sd, sel_n, upd_n;
    int err_total = 0, checks = 0;
    localparam logic [79:0] PAT_A = 80'hA5C3_0F96_1234_5678_9ABC;
    localparam logic [79:0] PAT_B = 80'h5A3C_F069_EDCB_A987_6543;
    initial forever #50 i_clock = ~i_clock;
    xps_host host_u (.i_clock(i_clock), .o_sck(sck), .o_sdata(sd), .o_sel_n(sel_n),
        .o_upd_n(upd_n));
    xps_chain dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_clock(sck),
        .i_serial_data(sd), .i_select_n(sel_n), .i_update_n(upd_n), .o_serial_data(sout),
        .o_matrix(mat), .o_outputs_enable_n(oe_n));
    // Second device is chained behind the first through its serial output.
    xps_chain dut2_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_clock(sck),
        .i_serial_data(sout), .i_select_n(sel_n), .i_update_n(upd_n), .o_serial_data(sout2),
        .o_matrix(mat2), .o_outputs_enable_n(oe2_n));
    task chk(input logic ok);
        checks++;
        if (!ok) begin
            err_total++;
            $display("[FAIL] %0t mismatch", $time);
        end
    endtask
    task tally_and_finish();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task t_reset();
        i_rst_n = 0;
        host_u.wait_n(2);
        chk(oe_n === 1'b1 && mat === '0 && oe2_n === 1'b1 && mat2 === '0);
        i_rst_n = 1;
        $display("t_reset done");
    endtask
    task t_load(input logic [79:0] w, input logic [79:0] old, input logic oe);
        host_u.shift_word(w);
        host_u.wait_n(3);
        chk(mat === old && oe_n === oe && sout === w[79]);
        host_u.strobe();
        chk(mat === w && oe_n === 1'b0);
        $display("t_load done");
    endtask
    task t_chain();
        host_u.shift_word(~PAT_A);
        host_u.shift_word(PAT_B);
        host_u.wait_n(3);
        chk(mat2 === PAT_A && sout2 === ~PAT_A[79]);
        host_u.strobe();
        chk(mat === PAT_B && mat2 === ~PAT_A && oe2_n === 1'b0);
        $display("t_chain done");
    endtask
    task t_deselect();
        host_u.sel(1'b1);
        host_u.shift_word(PAT_A);
        host_u.strobe();
        chk(mat === PAT_B && sout === PAT_B[79]);
        $display("t_deselect done");
    endtask
    initial begin
        t_reset();
        host_u.sel(1'b0);
        t_load(PAT_A, '0, 1'b1);
        t_load(PAT_B, PAT_A, 1'b0);
        t_chain();
        t_deselect();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
